// ---- rtl/feam_ctrl.v ----
// Erase and address-mode command handling of a serial NOR flash.
// Assumes the host drives chip select, serial clock and data; array erase is
// performed by logic outside on erase_start and finished when the cycle ends.
`timescale 1ns/1ps
`include "feam_defs.vh"
module feam_ctrl #(
	parameter [31:0] SECTOR_ERASE_CYC = `FEAM_SECTOR_ERASE_US * `FEAM_CLK_MHZ,
	parameter [31:0] HALF_ERASE_CYC = `FEAM_HALF_ERASE_US * `FEAM_CLK_MHZ,
	parameter [31:0] BLOCK_ERASE_CYC = `FEAM_BLOCK_ERASE_US * `FEAM_CLK_MHZ,
	parameter [31:0] CHIP_ERASE_CYC = `FEAM_CHIP_ERASE_US * `FEAM_CLK_MHZ
) (
	input wire clk,
	input wire rst_n,
	input wire spi_cs_n,
	input wire spi_clk,
	input wire serial_in,
	input wire [2:0] quad_data_hi,
	input wire protect_complement,
	input wire protect_top_bottom,
	input wire protect_level_bit3,
	input wire protect_level_bit2,
	input wire protect_level_bit1,
	input wire protect_level_bit0,
	output wire write_in_progress,
	output wire write_enable_latch,
	output wire wide_address_flag,
	output wire quad_command_mode,
	output wire [7:0] ext_addr_reg,
	output wire erase_start,
	output wire [1:0] erase_kind,
	output wire [31:0] erase_addr,
	output wire erase_done,
	output wire cmd_rejected
);
	wire bit_stb;
	wire [3:0] bit_data;
	wire frame_start;
	wire frame_end;
	wire busy;

	reg [5:0] cnt_r, cnt_nxt;
	reg [39:0] sh_r, sh_nxt;
	reg [7:0] opc_r;
	reg we_latch_r;
	reg wide_r;
	reg quad_r;
	reg [7:0] ext_r;
	reg start_r;
	reg [1:0] kind_r;
	reg [31:0] addr_r;
	reg rej_r;
	reg [1:0] st_r, st_nxt;

	localparam ST_IDLE = 2'd0;
	localparam ST_LAUNCH = 2'd1;
	localparam ST_RUN = 2'd2;

	feam_spi_rx u_rx (
		.clk(clk),
		.rst_n(rst_n),
		.spi_cs_n(spi_cs_n),
		.spi_clk(spi_clk),
		.pin_data({quad_data_hi, serial_in}),
		.bit_stb(bit_stb),
		.bit_data(bit_data),
		.frame_start(frame_start),
		.frame_end(frame_end)
	);

	feam_erase_timer #(
		.SECTOR_CYC(SECTOR_ERASE_CYC),
		.HALF_CYC(HALF_ERASE_CYC),
		.BLOCK_CYC(BLOCK_ERASE_CYC),
		.CHIP_CYC(CHIP_ERASE_CYC)
	) u_timer (
		.clk(clk),
		.rst_n(rst_n),
		.start(start_r),
		.kind(kind_r),
		.busy(busy),
		.done(erase_done)
	);

	// Shift in one bit, or a nibble in quad format
	always @* begin
		cnt_nxt = cnt_r;
		sh_nxt = sh_r;
		if (frame_start) begin
			cnt_nxt = 6'd0;
		end else if (bit_stb) begin
			if (quad_r) begin
				sh_nxt = {sh_r[35:0], bit_data};
				cnt_nxt = (cnt_r > `FEAM_BITS_MAX - 6'd4) ? `FEAM_BITS_MAX : cnt_r + 6'd4;
			end else begin
				sh_nxt = {sh_r[38:0], bit_data[0]};
				cnt_nxt = (cnt_r == `FEAM_BITS_MAX) ? `FEAM_BITS_MAX : cnt_r + 6'd1;
			end
		end
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= 6'd0;
			sh_r <= 40'h0;
			opc_r <= 8'h00;
		end else begin
			cnt_r <= cnt_nxt;
			sh_r <= sh_nxt;
			// A frame too short for an opcode must not reuse the last one
			if (frame_start)
				opc_r <= 8'h00;
			else if (bit_stb && cnt_nxt == `FEAM_BITS_OPC)
				opc_r <= sh_nxt[7:0];
		end
	end

	// Protection decode
	wire [3:0] prot_lvl = {protect_level_bit3, protect_level_bit2, protect_level_bit1, protect_level_bit0};
	reg [10:0] prot_blocks;

	always @* begin
		if (prot_lvl == 4'h0)
			prot_blocks = 11'h000;
		else if (prot_lvl >= `FEAM_LVL_ALL)
			prot_blocks = `FEAM_MEM_BLOCKS;
		else
			prot_blocks = 11'h001 << (prot_lvl - 4'h1);
	end

	// Complement swaps the protected and unprotected sides
	wire any_prot = protect_complement ? (prot_blocks != `FEAM_MEM_BLOCKS) : (prot_blocks != 11'h000);

	// Command decode at frame end
	wire wide_cmd = (opc_r == `FEAM_OP_SECTOR_WIDE) || (opc_r == `FEAM_OP_HALF_WIDE) ||
		(opc_r == `FEAM_OP_BLOCK64_WIDE);
	wire addr_cmd = wide_cmd || (opc_r == `FEAM_OP_BLOCK64);
	wire chip_cmd = (opc_r == `FEAM_OP_CHIP_A) || (opc_r == `FEAM_OP_CHIP_B);
	wire four_bytes = wide_cmd || wide_r;
	wire [5:0] need_bits = four_bytes ? `FEAM_BITS_ADDR4 : `FEAM_BITS_ADDR3;
	wire [31:0] raw_addr = four_bytes ? sh_r[31:0] : {ext_r, sh_r[23:0]};
	wire [9:0] tgt_blk = raw_addr[`FEAM_BLK_MSB:`FEAM_BLK_LSB];
	wire in_low = {1'b0, tgt_blk} < prot_blocks;
	wire in_high = {1'b0, tgt_blk} >= (`FEAM_MEM_BLOCKS - prot_blocks);
	// Sector and half block sit inside one 64KB block, so a block check covers them
	wire blk_prot = (protect_top_bottom ? in_low : in_high) ^ protect_complement;
	wire exact_opc = (cnt_r == `FEAM_BITS_OPC);

	reg [1:0] dec_kind;
	reg [31:0] dec_mask;

	always @* begin
		case (opc_r)
			`FEAM_OP_SECTOR_WIDE: begin
				dec_kind = `FEAM_KIND_SECTOR;
				dec_mask = `FEAM_MASK_SECTOR;
			end
			`FEAM_OP_HALF_WIDE: begin
				dec_kind = `FEAM_KIND_HALF;
				dec_mask = `FEAM_MASK_HALF;
			end
			default: begin
				dec_kind = `FEAM_KIND_BLOCK;
				dec_mask = `FEAM_MASK_BLOCK;
			end
		endcase
	end

	wire addr_ok = addr_cmd && we_latch_r && (cnt_r == need_bits) && !blk_prot;
	wire chip_ok = chip_cmd && we_latch_r && exact_opc && !any_prot;
	// Launch gap counts as busy: the timer rises two cycles after acceptance
	wire engaged = (st_r == ST_LAUNCH) || busy;
	wire erase_go = frame_end && !engaged && (addr_ok || chip_ok);
	wire erase_try = frame_end && (addr_cmd || chip_cmd);

	// Erase cycle tracking
	always @* begin
		st_nxt = st_r;
		case (st_r)
			ST_IDLE: begin
				if (erase_go)
					st_nxt = ST_LAUNCH;
			end
			ST_LAUNCH: begin
				if (busy)
					st_nxt = ST_RUN;
			end
			ST_RUN: begin
				if (!busy)
					st_nxt = ST_IDLE;
			end
			default: begin
				st_nxt = ST_IDLE;
			end
		endcase
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			st_r <= ST_IDLE;
		else
			st_r <= st_nxt;
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			we_latch_r <= 1'b0;
			wide_r <= 1'b0;
			quad_r <= 1'b0;
			ext_r <= `FEAM_RST_EXT;
			start_r <= 1'b0;
			kind_r <= `FEAM_KIND_SECTOR;
			addr_r <= 32'h0;
			rej_r <= 1'b0;
		end else begin
			start_r <= erase_go;
			rej_r <= erase_try && !erase_go;
			if (erase_go) begin
				we_latch_r <= 1'b0;
				if (chip_ok) begin
					kind_r <= `FEAM_KIND_CHIP;
					addr_r <= 32'h0;
				end else begin
					kind_r <= dec_kind;
					addr_r <= raw_addr & dec_mask;
					if (wide_r)
						ext_r <= raw_addr[31:24];
				end
			end else if (frame_end && !engaged) begin
				case (opc_r)
					`FEAM_OP_WRITE_ENABLE: begin
						if (exact_opc)
							we_latch_r <= 1'b1;
					end
					`FEAM_OP_WRITE_DISABLE: begin
						if (exact_opc)
							we_latch_r <= 1'b0;
					end
					`FEAM_OP_ENTER_WIDE: begin
						if (exact_opc)
							wide_r <= 1'b1;
					end
					`FEAM_OP_EXIT_WIDE: begin
						if (exact_opc)
							wide_r <= 1'b0;
					end
					`FEAM_OP_ENTER_QUAD: begin
						if (exact_opc)
							quad_r <= 1'b1;
					end
					`FEAM_OP_EXIT_QUAD: begin
						if (exact_opc && quad_r)
							quad_r <= 1'b0;
					end
					`FEAM_OP_WR_EXT: begin
						if (we_latch_r && cnt_r == `FEAM_BITS_EXT) begin
							ext_r <= sh_r[7:0];
							we_latch_r <= 1'b0;
						end
					end
					default: begin
						we_latch_r <= we_latch_r;
					end
				endcase
			end
		end
	end

	assign write_in_progress = busy;
	assign write_enable_latch = we_latch_r;
	assign wide_address_flag = wide_r;
	assign quad_command_mode = quad_r;
	assign ext_addr_reg = ext_r;
	assign erase_start = start_r;
	assign erase_kind = kind_r;
	assign erase_addr = addr_r;
	assign cmd_rejected = rej_r;
endmodule // feam_ctrl

// ---- rtl/feam_defs.vh ----
// Constants for the erase and address-mode command block.
// Assumes a 40 MHz core clock and a 512 Mbit array of 1024 blocks of 64 KB.
`ifndef FEAM_DEFS_VH
`define FEAM_DEFS_VH

`define FEAM_CLK_MHZ 40

// Opcodes
`define FEAM_OP_WRITE_ENABLE 8'h06
`define FEAM_OP_WRITE_DISABLE 8'h04
`define FEAM_OP_BLOCK64 8'hD8
`define FEAM_OP_SECTOR_WIDE 8'h21
`define FEAM_OP_HALF_WIDE 8'h5C
`define FEAM_OP_BLOCK64_WIDE 8'hDC
`define FEAM_OP_CHIP_A 8'hC7
`define FEAM_OP_CHIP_B 8'h60
`define FEAM_OP_ENTER_WIDE 8'hB7
`define FEAM_OP_EXIT_WIDE 8'hE9
`define FEAM_OP_ENTER_QUAD 8'h38
`define FEAM_OP_EXIT_QUAD 8'hFF
`define FEAM_OP_WR_EXT 8'hC5

// Bit counts of a complete frame, and the ceiling at which the bit counter saturates
`define FEAM_BITS_OPC 6'd8
`define FEAM_BITS_EXT 6'd16
`define FEAM_BITS_ADDR3 6'd32
`define FEAM_BITS_ADDR4 6'd40
`define FEAM_BITS_MAX 6'd63

// Erase kinds
`define FEAM_KIND_SECTOR 2'd0
`define FEAM_KIND_HALF 2'd1
`define FEAM_KIND_BLOCK 2'd2
`define FEAM_KIND_CHIP 2'd3

// Region alignment masks
`define FEAM_MASK_SECTOR 32'hFFFFF000
`define FEAM_MASK_HALF 32'hFFFF8000
`define FEAM_MASK_BLOCK 32'hFFFF0000

// Protection geometry
`define FEAM_BLK_MSB 25
`define FEAM_BLK_LSB 16
`define FEAM_MEM_BLOCKS 11'h400
`define FEAM_LVL_ALL 4'hB

// Reset values
`define FEAM_RST_EXT 8'h00

// Erase times in microseconds (plain defaults)
`define FEAM_SECTOR_ERASE_US 100
`define FEAM_HALF_ERASE_US 200
`define FEAM_BLOCK_ERASE_US 300
`define FEAM_CHIP_ERASE_US 1000

`endif

// ---- rtl/feam_spi_rx.v ----
// Pin sampler for the serial command port.
// Assumes the serial clock is well below a quarter of clk; all pins are asynchronous.
`timescale 1ns/1ps
module feam_spi_rx (
	input wire clk,
	input wire rst_n,
	input wire spi_cs_n,
	input wire spi_clk,
	input wire [3:0] pin_data,
	output wire bit_stb,
	output wire [3:0] bit_data,
	output wire frame_start,
	output wire frame_end
);
	reg cs_s1_r, cs_s2_r, cs_s3_r;
	reg ck_s1_r, ck_s2_r, ck_s3_r;
	reg [3:0] d_s1_r, d_s2_r;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cs_s1_r <= 1'b1;
			cs_s2_r <= 1'b1;
			cs_s3_r <= 1'b1;
			ck_s1_r <= 1'b0;
			ck_s2_r <= 1'b0;
			ck_s3_r <= 1'b0;
			d_s1_r <= 4'h0;
			d_s2_r <= 4'h0;
		end else begin
			cs_s1_r <= spi_cs_n;
			cs_s2_r <= cs_s1_r;
			cs_s3_r <= cs_s2_r;
			ck_s1_r <= spi_clk;
			ck_s2_r <= ck_s1_r;
			ck_s3_r <= ck_s2_r;
			d_s1_r <= pin_data;
			d_s2_r <= d_s1_r;
		end
	end

	// Data passes the same two stages as the clock, so it lines up with the edge
	assign bit_stb = ck_s2_r & ~ck_s3_r & ~cs_s2_r;
	assign bit_data = d_s2_r;
	assign frame_start = ~cs_s2_r & cs_s3_r;
	assign frame_end = cs_s2_r & ~cs_s3_r;
endmodule // feam_spi_rx

// ---- rtl/feam_erase_timer.v ----
// Self-timed erase cycle counter.
// Assumes start only arrives while idle; durations are in clk cycles.
`timescale 1ns/1ps
`include "feam_defs.vh"
module feam_erase_timer #(
	parameter [31:0] SECTOR_CYC = 32'd4000,
	parameter [31:0] HALF_CYC = 32'd8000,
	parameter [31:0] BLOCK_CYC = 32'd12000,
	parameter [31:0] CHIP_CYC = 32'd40000
) (
	input wire clk,
	input wire rst_n,
	input wire start,
	input wire [1:0] kind,
	output wire busy,
	output wire done
);
	reg busy_r;
	reg [31:0] cnt_r;
	reg [31:0] dur;

	always @* begin
		case (kind)
			`FEAM_KIND_SECTOR: dur = SECTOR_CYC;
			`FEAM_KIND_HALF: dur = HALF_CYC;
			`FEAM_KIND_BLOCK: dur = BLOCK_CYC;
			default: dur = CHIP_CYC;
		endcase
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			busy_r <= 1'b0;
			cnt_r <= 32'h0;
		end else if (start && !busy_r) begin
			busy_r <= 1'b1;
			cnt_r <= dur - 32'd1;
		end else if (busy_r) begin
			if (cnt_r == 32'h0)
				busy_r <= 1'b0;
			else
				cnt_r <= cnt_r - 32'd1;
		end
	end

	assign busy = busy_r;
	assign done = busy_r && (cnt_r == 32'h0);
endmodule // feam_erase_timer

// ---- tb/feam_ctrl_sva.sv ----
// Port checker for the erase and address-mode block.
// Assumes erase lengths are the instance's own parameters.
`timescale 1ns/1ps
module feam_ctrl_sva #(
	parameter [31:0] SECTOR_ERASE_CYC = 32'h0000000A,
	parameter [31:0] HALF_ERASE_CYC = 32'h00000014,
	parameter [31:0] BLOCK_ERASE_CYC = 32'h0000001E,
	parameter [31:0] CHIP_ERASE_CYC = 32'h00000028
) (
	input wire clk,
	input wire rst_n,
	input wire protect_complement,
	input wire protect_level_bit3,
	input wire protect_level_bit2,
	input wire protect_level_bit1,
	input wire protect_level_bit0,
	input wire write_in_progress,
	input wire write_enable_latch,
	input wire erase_start,
	input wire [1:0] erase_kind,
	input wire [31:0] erase_addr,
	input wire erase_done
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	reg [31:0] len_r;
	reg [1:0] kind_r;
	wire [3:0] lvl = {protect_level_bit3, protect_level_bit2, protect_level_bit1, protect_level_bit0};
	wire [31:0] exp_len = kind_r == 2'h0 ? SECTOR_ERASE_CYC : kind_r == 2'h1 ? HALF_ERASE_CYC :
		kind_r == 2'h2 ? BLOCK_ERASE_CYC : CHIP_ERASE_CYC;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			len_r <= 32'h00000000;
			kind_r <= 2'h0;
		end else begin
			len_r <= write_in_progress ? len_r + 32'h00000001 : 32'h00000000;
			if (erase_start)
				kind_r <= erase_kind;
		end
	end
	property p_needs_wel; erase_start |-> $past(write_enable_latch); endproperty
	a_needs_wel: assert property (p_needs_wel) else $error("erase without latch");
	property p_wel_clr; erase_start |=> !write_enable_latch; endproperty
	a_wel_clr: assert property (p_wel_clr) else $error("latch not cleared");
	property p_start_wip; erase_start |=> write_in_progress; endproperty
	a_start_wip: assert property (p_start_wip) else $error("busy not raised");
	property p_len; $fell(write_in_progress) |-> len_r == exp_len; endproperty
	a_len: assert property (p_len) else $error("erase length wrong");
	property p_done; erase_done |-> write_in_progress ##1 !write_in_progress; endproperty
	a_done: assert property (p_done) else $error("done not last busy cycle");
	property p_fell; $fell(write_in_progress) |-> $past(erase_done); endproperty
	a_fell: assert property (p_fell) else $error("busy fell without done");
	property p_busy; write_in_progress |-> !erase_start; endproperty
	a_busy: assert property (p_busy) else $error("start while busy");
	property p_blk; erase_start && erase_kind == 2'h2 |-> erase_addr[15:0] == 16'h0000; endproperty
	a_blk: assert property (p_blk) else $error("block base unaligned");
	property p_chip; erase_start && erase_kind == 2'h3 |-> erase_addr == 32'h00000000; endproperty
	a_chip: assert property (p_chip) else $error("chip base not zero");
	property p_prot; erase_start && erase_kind == 2'h3 && !protect_complement |-> lvl == 4'h0; endproperty
	a_prot: assert property (p_prot) else $error("chip erase while protected");
endmodule // feam_ctrl_sva
bind feam_ctrl feam_ctrl_sva #(.SECTOR_ERASE_CYC(SECTOR_ERASE_CYC), .HALF_ERASE_CYC(HALF_ERASE_CYC),
	.BLOCK_ERASE_CYC(BLOCK_ERASE_CYC), .CHIP_ERASE_CYC(CHIP_ERASE_CYC)) u_sva (.clk(clk), .rst_n(rst_n),
	.protect_complement(protect_complement), .protect_level_bit3(protect_level_bit3),
	.protect_level_bit2(protect_level_bit2), .protect_level_bit1(protect_level_bit1),
	.protect_level_bit0(protect_level_bit0), .write_in_progress(write_in_progress),
	.write_enable_latch(write_enable_latch), .erase_start(erase_start), .erase_kind(erase_kind),
	.erase_addr(erase_addr), .erase_done(erase_done));

// ---- tb/feam_host_model.sv ----
// Host serial controller model: select, serial clock and data lines.
// Assumes callers leave idle time between frames; serial clock idles low.
`timescale 1ns/1ps
module feam_host_model (
	output logic spi_cs_n,
	output logic spi_clk,
	output logic serial_in,
	output logic [2:0] quad_data_hi
);
	initial begin
		spi_cs_n = 1'b1;
		spi_clk = 1'b0;
		serial_in = 1'b1;
		quad_data_hi = 3'h5;
	end
	// MSB first, a bit or a nibble per rising serial clock edge
	task automatic xfer(input [39:0] d, input [5:0] n, input q);
		int i;
		begin
			i = n;
			spi_cs_n = 1'b0;
			while (i > 0) begin
				if (q)
					{quad_data_hi, serial_in} = d[i-1 -: 4];
				else
					serial_in = d[i-1];
				#100 spi_clk = 1'b1;
				#100 spi_clk = 1'b0;
				i = q ? i - 4 : i - 1;
			end
			#100 spi_cs_n = 1'b1;
			// Released lines flip so a held value is never mistaken for data
			serial_in = ~serial_in;
			quad_data_hi = ~quad_data_hi;
			#200;
		end
	endtask
endmodule // feam_host_model

// ---- tb/feam_ctrl_tb_top.sv ----
// Directed bench for the erase and address-mode block.
// Assumes shortened erase lengths; the host model makes the serial clock.
`timescale 1ns/1ps
module feam_ctrl_tb_top;
	reg clk, rst_n, pcomp, tbot, l3, l2, l1, l0, qm;
	wire cs_n, sck, sdi, busy_o, latch_o, wide, quad, st, dn, rej;
	wire [2:0] qhi;
	wire [7:0] ext;
	wire [1:0] kind;
	wire [31:0] addr;
	integer bad_count = 0, n_compared = 0, n_st = 0, n_rej = 0, wlen = 0;
	reg [1:0] k_r;
	reg [31:0] a_r;
	feam_ctrl #(.SECTOR_ERASE_CYC(32'h0000000A), .HALF_ERASE_CYC(32'h00000014),
		.BLOCK_ERASE_CYC(32'h0000001E), .CHIP_ERASE_CYC(32'h00000190)) u_dut (.clk(clk), .rst_n(rst_n),
		.spi_cs_n(cs_n), .spi_clk(sck), .serial_in(sdi), .quad_data_hi(qhi), .protect_complement(pcomp),
		.protect_top_bottom(tbot), .protect_level_bit3(l3), .protect_level_bit2(l2), .protect_level_bit1(l1),
		.protect_level_bit0(l0), .write_in_progress(busy_o), .write_enable_latch(latch_o), .wide_address_flag(wide),
		.quad_command_mode(quad), .ext_addr_reg(ext), .erase_start(st), .erase_kind(kind),
		.erase_addr(addr), .erase_done(dn), .cmd_rejected(rej));
	feam_host_model u_host (.spi_cs_n(cs_n), .spi_clk(sck), .serial_in(sdi), .quad_data_hi(qhi));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// Falling edge keeps the monitor clear of register updates
	always @(negedge clk) begin
		if (st === 1'b1) begin
			n_st = n_st + 1;
			k_r = kind;
			a_r = addr;
		end
		if (rej === 1'b1)
			n_rej = n_rej + 1;
		if (busy_o === 1'b1)
			wlen = wlen + 1;
	end
	task chk(input [31:0] seen, input [31:0] exp);
		n_compared = n_compared + 1;
		if (seen !== exp) begin
			bad_count = bad_count + 1;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task wrap_up;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task send(input [39:0] d, input [5:0] n);
		@(posedge clk);
		#2;
		u_host.xfer(d, n, qm);
		repeat (6) @(posedge clk);
		#2;
	endtask
	// Frame, wait out busy, then check starts, refusals, kind, base and length
	task erase(input [39:0] d, input [5:0] n, input [31:0] ns, input [31:0] nr, input [1:0] ek,
		input [31:0] ea, input [31:0] el);
		int s0, r0, i;
		begin
			s0 = n_st;
			r0 = n_rej;
			wlen = 0;
			i = 0;
			send(d, n);
			while (busy_o !== 1'b0 && i < 600) begin
				@(posedge clk);
				#2;
				i = i + 1;
			end
			chk(n_st - s0, ns);
			chk(n_rej - r0, nr);
			if (ns != 0) begin
				chk(k_r, ek);
				chk(a_r, ea);
				chk(wlen, el);
				chk(latch_o, 0);
			end
		end
	endtask
	initial begin
		{pcomp, tbot, l3, l2, l1, l0, qm} = 7'h00;
		rst_n = 1'b0;
		repeat (20) @(posedge clk);
		#2 rst_n = 1'b1;
		repeat (4) @(posedge clk);
		chk(wide, 0);
		chk(ext, 0);
		erase({8'hD8, 24'h123456}, 32, 0, 1, 0, 0, 0);
		send(8'h06, 8);
		chk(latch_o, 1);
		erase({8'hD8, 24'h123456}, 32, 1, 0, 2, 32'h00120000, 30);
		send(8'h06, 8);
		erase({8'hD8, 32'h00123456}, 40, 0, 1, 0, 0, 0);
		send(8'h06, 8);
		erase({8'h21, 32'h01234567}, 40, 1, 0, 0, 32'h01234000, 10);
		send(8'h06, 8);
		erase({8'h5C, 32'h01234567}, 40, 1, 0, 1, 32'h01230000, 20);
		send(8'h06, 8);
		erase({8'hDC, 32'h03FFFFFF}, 40, 1, 0, 2, 32'h03FF0000, 30);
		send(8'h06, 8);
		erase(8'hC7, 8, 1, 0, 3, 0, 400);
		send(8'h06, 8);
		erase(8'h60, 8, 1, 0, 3, 0, 400);
		send(8'h06, 8);
		erase({8'hC7, 8'h00}, 16, 0, 1, 0, 0, 0);
		send(8'hB7, 8);
		chk(wide, 1);
		send(8'h06, 8);
		erase({8'hD8, 32'h02345678}, 40, 1, 0, 2, 32'h02340000, 30);
		send(8'hE9, 8);
		chk(wide, 0);
		send(8'h06, 8);
		send({8'hC5, 8'h03}, 16);
		chk(ext, 8'h03);
		send(8'h06, 8);
		erase({8'hD8, 24'h000000}, 32, 1, 0, 2, 32'h03000000, 30);
		l0 = 1'b1;
		send(8'h06, 8);
		erase({8'hDC, 32'h03FF1234}, 40, 0, 1, 0, 0, 0);
		send(8'h06, 8);
		erase(8'hC7, 8, 0, 1, 0, 0, 0);
		l0 = 1'b0;
		send(8'h06, 8);
		send(8'hC7, 8);
		send(8'hB7, 8);
		chk(wide, 0);
		repeat (500) @(posedge clk);
		send(8'h38, 8);
		chk(quad, 1);
		qm = 1'b1;
		send(8'h06, 8);
		erase({8'h21, 32'h00005678}, 40, 1, 0, 0, 32'h00005000, 10);
		send(8'hFF, 8);
		qm = 1'b0;
		chk(quad, 0);
		wrap_up;
	end
	initial begin
		#1000000;
		bad_count = bad_count + 1;
		wrap_up;
	end
endmodule // feam_ctrl_tb_top
